// *** core/eeprom_access_pkg.sv ***
// shared constants and types for the eeprom byte access controller
package eeprom_access_pkg;

	// storage geometry
	localparam int EEPROM_BYTES = 512;
	localparam int EE_ADDR_W = 9;

	// wishbone slave geometry
	localparam int WB_ADR_W = 8;
	localparam int WB_DAT_W = 32;
	localparam int REG_IDX_W = 6;

	// register indices; byte address is four times the index
	localparam logic [REG_IDX_W-1:0] CTRL_IDX = 6'h1F;
	localparam logic [REG_IDX_W-1:0] DATA_IDX = 6'h20;
	localparam logic [REG_IDX_W-1:0] ADDR_LO_IDX = 6'h21;
	localparam logic [REG_IDX_W-1:0] ADDR_HI_IDX = 6'h22;
	localparam logic [REG_IDX_W-1:0] STATUS_IDX = 6'h23;

	// nvm_control_reg field positions
	localparam int READ_STROBE_BIT = 0;
	localparam int WRITE_STROBE_BIT = 1;
	localparam int WRITE_ARM_BIT = 2;
	localparam int READY_IRQ_EN_BIT = 3;

	// status register field positions
	localparam int SELFPROG_BIT = 0;

	// values after reset
	localparam logic [EE_ADDR_W-1:0] ADDR_RESET = 9'h000;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// cycle counts on ref_clk
	localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
	localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
	localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;

	// write duration in calibrated rc oscillator cycles, about 3.3 ms
	localparam int WRITE_RC_CYCLES = 27072;
	localparam int RC_CNT_W = 15;

	// one byte write handed to the array
	typedef struct packed {
		logic [EE_ADDR_W-1:0] addr;
		logic [7:0] data;
	} wr_req_s;

	// write engine states, one-hot
	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_TIMING = 2'b10
	} wr_state_e;

endpackage : eeprom_access_pkg

// *** core/nvm_byte_array.sv ***
// byte-wide eeprom storage with self-timed write engine
`timescale 1ns/10ps
`default_nettype none

module nvm_byte_array #(
	parameter int WRITE_CYCLES = eeprom_access_pkg::WRITE_RC_CYCLES
) (
	// clock and power-on reset
	input wire logic ref_clk,
	input wire logic por_rst,
	// rc oscillator tick, one ref_clk pulse per rc cycle
	input wire logic rc_tick,
	// write request
	input wire logic wr_start,
	input wire eeprom_access_pkg::wr_req_s wr_req,
	// read port
	input wire logic rd_en,
	input wire logic [eeprom_access_pkg::EE_ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data,
	// write in progress
	output logic busy
);
	import eeprom_access_pkg::*;

	localparam logic [RC_CNT_W-1:0] LAST_TICK = RC_CNT_W'(WRITE_CYCLES - 1);

	logic [7:0] mem [EEPROM_BYTES];
	wr_state_e state;
	logic [RC_CNT_W-1:0] tick_cnt;

	// cell array, one byte per address RULE1
	always_ff @(posedge ref_clk)
	begin
		if (wr_start && state == WR_IDLE)
			mem[wr_req.addr] <= wr_req.data; // RULE1
		if (rd_en)
			rd_data <= mem[rd_addr]; // RULE1
	end

	// only power-on reset stops a write; system reset leaves it running
	always_ff @(posedge ref_clk)
	begin
		if (por_rst)
		begin
			state <= WR_IDLE;
			tick_cnt <= '0;
		end
		else
		begin
			case (state)
				WR_IDLE:
				begin
					tick_cnt <= '0;
					if (wr_start)
						state <= WR_TIMING;
				end
				WR_TIMING:
				begin
					if (rc_tick)
					begin
						if (tick_cnt == LAST_TICK)
							state <= WR_IDLE; // RULE7 RULE15
						else
							tick_cnt <= tick_cnt + 1'b1; // RULE7
					end
				end
				default:
					state <= WR_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (por_rst)
			busy <= 1'b0;
		else if (state == WR_IDLE)
			busy <= wr_start;
		else if (rc_tick && tick_cnt == LAST_TICK)
			busy <= 1'b0; // RULE6
	end

endmodule : nvm_byte_array
`default_nettype wire

// *** core/eeprom_cpu_access.sv ***
// processor-side controller for byte access to the on-chip eeprom
//
// Summary of operation
// RULE1: 512 separate eeprom bytes, each read or written alone.
// RULE2: a triggered read stalls the core four clock cycles.
// RULE3: setting the write strobe stalls the core two clock cycles.
// RULE4: software arms with strobe zero, then strobes within four cycles.
// RULE5: a strobe after the arm window expired writes nothing.
// RULE6: hardware clears the write strobe when the write time is over.
// RULE7: write lasts 27072 calibrated rc oscillator cycles, about 3.3 ms.
// RULE8: during a write, no read and no address change.
// RULE9: no eeprom write starts while flash self-programming is active.
// RULE10: software waits for strobe and self-programming flag to read zero.
// RULE11: address and data may be loaded in either order before arming.
// RULE12: software polls the strobe zero before triggering a read.
// RULE13: software keeps interrupts off through the write sequence.
// RULE14: power-down does not stop a write; oscillator kept running.
// RULE15: a reset during a write still lets the write finish.
// RULE16: the arm bit clears itself four cycles after being set.
// RULE17: strobe with arm clear has no effect.
// RULE18: read strobe loads the addressed byte into the data register.
// RULE19: ready interrupt stays asserted while enabled and strobe clear.
// RULE20: core holds its program counter while the stall output is high.
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

module eeprom_cpu_access #(
	parameter int WRITE_CYCLES = eeprom_access_pkg::WRITE_RC_CYCLES
) (
	// clock and resets
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic por_rst,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [eeprom_access_pkg::WB_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [eeprom_access_pkg::WB_DAT_W-1:0] wb_dat_i,
	output logic [eeprom_access_pkg::WB_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// calibrated rc oscillator, asynchronous to ref_clk
	input wire logic rc_osc,
	// core side status and control
	input wire logic flash_selfprog_active,
	output logic cpu_halt,
	output logic ready_irq,
	output logic osc_keep_running
);
	import eeprom_access_pkg::*;

	// register state
	logic [EE_ADDR_W-1:0] byte_address_reg;
	logic [7:0] byte_data_reg;
	logic ready_irq_enable;
	logic [2:0] arm_cnt;
	logic write_arm;
	logic [2:0] halt_cnt;
	logic rd_pending;

	// rc oscillator synchroniser and edge detect
	logic rc_meta;
	logic rc_sync;
	logic rc_prev;
	logic rc_tick;

	// array interface
	logic write_strobe_busy;
	logic wr_start;
	wr_req_s wr_req;
	logic rd_en;
	logic [7:0] rd_data;

	// bus decode
	logic [REG_IDX_W-1:0] reg_idx;
	logic bus_req;
	logic commit;
	logic wr_commit;
	logic lane0;
	logic ctrl_wr;
	logic [7:0] wbyte;
	logic next_ack;
	logic [WB_DAT_W-1:0] next_dat;
	logic [7:0] ctrl_view;

	// decoded requests
	logic sel_ctrl;
	logic sel_data;
	logic sel_addr_lo;
	logic sel_addr_hi;
	logic strobe_req;
	logic arm_req;
	logic read_req;
	logic engine_free;
	// stall and output shaping
	logic stall_load;
	logic [2:0] stall_len;
	logic next_ready_irq;
	logic next_osc_keep;

	assign reg_idx = wb_adr_i[WB_ADR_W-1:2];
	assign bus_req = wb_cyc_i && wb_stb_i;
	assign commit = bus_req && wb_ack_o;
	assign lane0 = wb_sel_i[0];
	assign wr_commit = commit && wb_we_i && lane0;
	assign wbyte = wb_dat_i[7:0];
	assign ctrl_wr = wr_commit && sel_ctrl;
	assign write_arm = arm_cnt != 3'h0;

	// one select per writable register; the status and unmapped indices select nothing
	always_comb
	begin
		sel_ctrl = 1'b0;
		sel_data = 1'b0;
		sel_addr_lo = 1'b0;
		sel_addr_hi = 1'b0;
		case (reg_idx)
			CTRL_IDX:
				sel_ctrl = 1'b1;
			DATA_IDX:
				sel_data = 1'b1;
			ADDR_LO_IDX:
				sel_addr_lo = 1'b1;
			ADDR_HI_IDX:
				sel_addr_hi = 1'b1;
			default:
				sel_ctrl = 1'b0;
		endcase
	end

	// decoded meanings of one control write
	assign strobe_req = ctrl_wr && wbyte[WRITE_STROBE_BIT];
	assign arm_req = ctrl_wr && wbyte[WRITE_ARM_BIT]
		&& !wbyte[WRITE_STROBE_BIT];
	assign read_req = ctrl_wr && wbyte[READ_STROBE_BIT]
		&& !wbyte[WRITE_STROBE_BIT];

	// flash programming owns the array supply, so a write strobe during it is dropped
	assign engine_free = !write_strobe_busy && !flash_selfprog_active;

	// a write starts only when armed, idle and flash not programming
	assign wr_start = strobe_req && write_arm
		&& engine_free; // RULE5 RULE9 RULE17

	// a read is refused while a write runs
	assign rd_en = read_req && !write_strobe_busy; // RULE8 RULE18

	assign wr_req.addr = byte_address_reg;
	assign wr_req.data = byte_data_reg;

	// rc synchroniser runs from power-on reset so a write keeps its timebase
	always_ff @(posedge ref_clk)
	begin
		if (por_rst)
		begin
			rc_meta <= 1'b0;
			rc_sync <= 1'b0;
			rc_prev <= 1'b0;
		end
		else
		begin
			rc_meta <= rc_osc;
			rc_sync <= rc_meta;
			rc_prev <= rc_sync;
		end
	end

	assign rc_tick = rc_sync && !rc_prev; // RULE7

	nvm_byte_array #(
		.WRITE_CYCLES(WRITE_CYCLES)
	) u_array (
		.ref_clk(ref_clk),
		.por_rst(por_rst),
		.rc_tick(rc_tick),
		.wr_start(wr_start),
		.wr_req(wr_req),
		.rd_en(rd_en),
		.rd_addr(byte_address_reg),
		.rd_data(rd_data),
		.busy(write_strobe_busy)
	);

	// address register, frozen while a write is in progress
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			byte_address_reg <= ADDR_RESET;
		else if (wr_commit && !write_strobe_busy) // RULE8
		begin
			if (sel_addr_lo)
				byte_address_reg[7:0] <= wbyte; // RULE11
			// upper half is one bit; the rest of that byte is ignored
			else if (sel_addr_hi)
				byte_address_reg[8] <= wbyte[0]; // RULE11
		end
	end

	// data register; a read result lands two cycles after the strobe
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			byte_data_reg <= DATA_RESET;
		else if (rd_pending)
			byte_data_reg <= rd_data; // RULE18
		else if (wr_commit && sel_data)
			byte_data_reg <= wbyte; // RULE11
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			rd_pending <= 1'b0;
		else
			rd_pending <= rd_en;
	end

	// ready interrupt enable
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			ready_irq_enable <= 1'b0;
		else if (ctrl_wr)
			ready_irq_enable <= wbyte[READY_IRQ_EN_BIT];
	end

	// arm window: armed only by a control write with strobe zero
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			arm_cnt <= 3'h0;
		else if (wr_start)
			arm_cnt <= 3'h0;
		else if (arm_req)
			arm_cnt <= ARM_WINDOW_CYCLES; // RULE4
		else if (write_arm)
			arm_cnt <= arm_cnt - 3'h1; // RULE16 RULE5
	end

	// a strobe write never also reads, so the write length wins
	always_comb
	begin
		stall_load = wr_start || rd_en;
		stall_len = READ_STALL_CYCLES;
		if (wr_start)
			stall_len = WRITE_STALL_CYCLES;
	end

	// core stall; no bus answer is given while it runs
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			halt_cnt <= 3'h0;
			cpu_halt <= 1'b0;
		end
		else if (stall_load)
		begin
			halt_cnt <= stall_len; // RULE2 RULE3
			cpu_halt <= 1'b1; // RULE20
		end
		else if (halt_cnt != 3'h0)
		begin
			halt_cnt <= halt_cnt - 3'h1;
			cpu_halt <= halt_cnt > 3'h1; // RULE2 RULE3
		end
		else
			cpu_halt <= 1'b0;
	end

	// read view of the control register; read strobe always reads zero
	always_comb
	begin
		ctrl_view = 8'h00;
		ctrl_view[WRITE_STROBE_BIT] = write_strobe_busy; // RULE6
		ctrl_view[WRITE_ARM_BIT] = write_arm;
		ctrl_view[READY_IRQ_EN_BIT] = ready_irq_enable;
	end

	// read mux; unmapped addresses read zero and take writes silently
	always_comb
	begin
		next_dat = 32'h0000_0000;
		case (reg_idx)
			CTRL_IDX:
				next_dat[7:0] = ctrl_view;
			DATA_IDX:
				next_dat[7:0] = byte_data_reg;
			ADDR_LO_IDX:
				next_dat[7:0] = byte_address_reg[7:0];
			ADDR_HI_IDX:
				next_dat[0] = byte_address_reg[8];
			STATUS_IDX:
				next_dat[SELFPROG_BIT] = flash_selfprog_active;
			default:
				next_dat = 32'h0000_0000;
		endcase
	end

	assign next_ack = bus_req && !wb_ack_o && halt_cnt == 3'h0; // RULE20

	// bus answer, one cycle after the request is seen
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= next_ack;
			if (next_ack)
				wb_dat_o <= next_dat;
		end
	end

	// both levels follow the engine; the oscillator covers the start cycle
	assign next_ready_irq = ready_irq_enable && !write_strobe_busy;
	assign next_osc_keep = write_strobe_busy || wr_start;

	// level interrupt, no sticky flag
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			ready_irq <= 1'b0;
		else
			ready_irq <= next_ready_irq; // RULE19
	end

	// oscillator must stay up through power-down until the write ends
	always_ff @(posedge ref_clk)
	begin
		if (por_rst)
			osc_keep_running <= 1'b0;
		else
			osc_keep_running <= next_osc_keep; // RULE14
	end

endmodule : eeprom_cpu_access
`default_nettype wire

// *** bench/eeprom_cpu_access_monitor.sv ***
// port checks for the eeprom access controller
`timescale 1ns/10ps
`default_nettype none
module eeprom_cpu_access_monitor #(
	parameter int WRITE_CYCLES = 8
) (
	// clock and resets
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic por_rst,
	// bus and core side
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [eeprom_access_pkg::WB_DAT_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic flash_selfprog_active,
	input wire logic cpu_halt,
	input wire logic ready_irq,
	input wire logic osc_keep_running
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst || por_rst);

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_prompt: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o && !cpu_halt |=> wb_ack_o)
		else $error("ack late");
	a_halt_no_ack: assert property (cpu_halt |-> !wb_ack_o)
		else $error("ack during stall");
	a_read_stall: assert property (
		$rose(cpu_halt) && !$rose(osc_keep_running)
		|-> cpu_halt[*4] ##1 !cpu_halt)
		else $error("read stall length");
	a_write_stall: assert property (
		$rose(osc_keep_running) |-> cpu_halt ##1 cpu_halt ##1 !cpu_halt)
		else $error("write stall length");
	a_no_flash_write: assert property (
		$rose(osc_keep_running) |-> !$past(flash_selfprog_active))
		else $error("write during self-programming");
	a_busy_irq_low: assert property (
		$rose(osc_keep_running) |=> !ready_irq)
		else $error("ready irq during write");
	a_dat_upper: assert property (
		wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read bits set");

	c_read: cover property ($rose(cpu_halt) && !osc_keep_running);
	c_write_end: cover property ($fell(osc_keep_running));
	c_irq: cover property ($rose(ready_irq));
endmodule : eeprom_cpu_access_monitor

bind eeprom_cpu_access eeprom_cpu_access_monitor #(
	.WRITE_CYCLES(WRITE_CYCLES)
) mon (
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.por_rst(por_rst),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.flash_selfprog_active(flash_selfprog_active),
	.cpu_halt(cpu_halt),
	.ready_irq(ready_irq),
	.osc_keep_running(osc_keep_running)
);
`default_nettype wire

// *** bench/core_model.sv ***
// core side model: bus master, rc oscillator, flash flag
`timescale 1ns/10ps
`default_nettype none
module core_model (
	// clock and answer
	input wire logic ref_clk,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// requests and core signals
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [31:0] dat,
	output logic rc_osc,
	output logic spm
);
	initial
	begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat = 32'h0000_0000;
		rc_osc = 1'b0;
		spm = 1'b0;
	end

	// free running, well under half the bus clock
	always #20 rc_osc = ~rc_osc;

	task automatic set_spm(input logic b);
		@(posedge ref_clk);
		spm <= b;
	endtask : set_spm

	task automatic acc(input logic w, input logic [7:0] a, d,
		output logic [31:0] q);
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h00_0000, d};
		// core holds its request while stalled
		do
			@(posedge ref_clk);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		dat <= ~dat;
	endtask : acc
endmodule : core_model
`default_nettype wire

// *** bench/eeprom_cpu_access_tb.sv ***
// self-checking bench for the eeprom access controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
	begin \
		tests_run++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("unexpected t=%0t got %h exp %h", $time, g, e); \
		end \
	end
module eeprom_cpu_access_tb;
	import eeprom_access_pkg::*;
	localparam logic [7:0] CTL = {CTRL_IDX, 2'b00};
	localparam logic [7:0] DAT = {DATA_IDX, 2'b00};
	localparam logic [7:0] ALO = {ADDR_LO_IDX, 2'b00};
	localparam logic [7:0] AHI = {ADDR_HI_IDX, 2'b00};
	localparam logic [7:0] STS = {STATUS_IDX, 2'b00};
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic por_rst = 1'b1;
	logic cyc, stb, we, rc_osc, spm, ack, halt, irq, osc;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, q;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;

	always #4 ref_clk = ~ref_clk;

	eeprom_cpu_access #(.WRITE_CYCLES(8)) dut (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .por_rst(por_rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.rc_osc(rc_osc), .flash_selfprog_active(spm), .cpu_halt(halt),
		.ready_irq(irq), .osc_keep_running(osc));

	core_model core (.ref_clk(ref_clk), .wb_dat_o(rdat), .wb_ack_o(ack),
		.cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(wdat),
		.rc_osc(rc_osc), .spm(spm));

	task automatic wrap_up;
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic wr(input logic [7:0] a, d);
		core.acc(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		core.acc(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask : rd_chk

	task automatic wait_idle;
		do
			core.acc(1'b0, CTL, 8'h00, q);
		while (q[1] !== 1'b0);
	endtask : wait_idle

	task automatic set_addr(input logic [8:0] a);
		wr(ALO, a[7:0]);
		wr(AHI, {7'h00, a[8]});
	endtask : set_addr

	task automatic put(input logic [8:0] a, input logic [7:0] d);
		wait_idle();
		set_addr(a);
		wr(DAT, d);
		wr(CTL, 8'h0C);
		wr(CTL, 8'h0A);
	endtask : put

	task automatic get(input logic [8:0] a, input logic [7:0] e);
		set_addr(a);
		wr(CTL, 8'h09);
		rd_chk(DAT, {24'h00_0000, e});
	endtask : get

	initial
	begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		por_rst <= 1'b0;
		rd_chk(CTL, 32'h0000_0000);
		rd_chk(8'h00, 32'h0000_0000);
		rd_chk(STS, 32'h0000_0000);
		`CHK(irq, 1'b0)
		wr(CTL, 8'h08);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'b1)
		put(9'h1A5, 8'h3C);
		rd_chk(CTL, 32'h0000_000A);
		`CHK(irq, 1'b0)
		`CHK(osc, 1'b1)
		wr(ALO, 8'h00);
		wr(CTL, 8'h09);
		@(posedge ref_clk);
		`CHK(halt, 1'b0)
		rd_chk(ALO, 32'h0000_00A5);
		wait_idle();
		@(posedge ref_clk);
		`CHK(irq, 1'b1)
		put(9'h000, 8'hC3);
		wait_idle();
		get(9'h1A5, 8'h3C);
		get(9'h000, 8'hC3);
		wr(DAT, 8'h55);
		wr(CTL, 8'h0A);
		rd_chk(CTL, 32'h0000_0008);
		wr(CTL, 8'h0C);
		repeat (5) @(posedge ref_clk);
		rd_chk(CTL, 32'h0000_0008);
		wr(CTL, 8'h0A);
		rd_chk(CTL, 32'h0000_0008);
		core.set_spm(1'b1);
		rd_chk(STS, 32'h0000_0001);
		wr(CTL, 8'h0C);
		wr(CTL, 8'h0A);
		rd_chk(CTL, 32'h0000_0008);
		core.set_spm(1'b0);
		get(9'h000, 8'hC3);
		put(9'h0F0, 8'h77);
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b1;
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		`CHK(osc, 1'b1)
		wait_idle();
		get(9'h0F0, 8'h77);
		wrap_up();
	end
endmodule : eeprom_cpu_access_tb
`default_nettype wire
